//--- hw/spcs_pkg.sv
// Constants, field layout and types of the switch port control block.
// Assumes a single 50 MHz APB clock domain for every user of it.
package spcs_pkg;
    // Ten ports, nine counters each, 32-bit counters
    localparam int NPORT = 10;
    localparam int NCNT = 9;
    localparam int CW = 32;
    // Global page word (byte address 12'h000)
    localparam logic [3:0] OFS_GLB = 4'h0;
    localparam int GLB_APPLY = 0;
    localparam int GLB_CLEAR = 1;
    // Port p uses page p+1: byte address (p+1)*12'h040 + word*4
    localparam logic [3:0] OFS_CFG = 4'h0;
    localparam logic [3:0] OFS_ACT = 4'h1;
    localparam logic [3:0] OFS_STAT = 4'h2;
    localparam logic [3:0] OFS_CNT0 = 4'h4;
    // Config field positions
    localparam int CFG_EN = 0;
    localparam int CFG_AN = 1;
    localparam int CFG_SPD = 2;
    localparam int CFG_DUP = 4;
    localparam int CFG_FC = 5;
    localparam int CFG_SEC = 6;
    // Status field positions
    localparam int ST_LINK = 0;
    localparam int ST_GIG = 1;
    localparam int ST_VALID = 2;
    localparam int ST_SPD = 3;
    localparam int ST_DUP = 5;
    localparam int ST_FC = 6;
    // Speed codes; 2'h3 marks a value that is not available
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1G = 2'h2;
    localparam logic [1:0] SPD_NA = 2'h3;
    // Reset configs: enabled, auto, full duplex, flow control, no security
    localparam logic [6:0] CFG_RST_FE = 7'h37;
    localparam logic [6:0] CFG_RST_GIG = 7'h3B;
    // Ports 6, 8 and 9 are gigabit copper/fibre, the rest are 100TX
    localparam logic [NPORT-1:0] MEDIA_GIG = 10'h340;
    // Pause time sent in every PAUSE request, in 512-bit-time quanta
    localparam logic [15:0] PAUSE_QUANTA = 16'hFFFF;
    // Counter indices
    localparam int CNT_TXG = 0;
    localparam int CNT_TXB = 1;
    localparam int CNT_RXG = 2;
    localparam int CNT_RXB = 3;
    localparam int CNT_ABT = 4;
    localparam int CNT_COL = 5;
    localparam int CNT_DRP = 6;
    localparam int CNT_BC = 7;
    localparam int CNT_MC = 8;
    typedef logic [6:0] spcs_cfg_type;
endpackage : spcs_pkg

//--- hw/spcs_cnt_if.sv
// Event and value bundle between the port logic and its counter bank.
// Assumes the same clock on both ends.
`timescale 1ns/100ps
interface spcs_cnt_if;
    import spcs_pkg::*;
    logic [NCNT-1:0] ev; // One-cycle count events
    logic clr; // Clear every counter
    logic [NCNT-1:0][CW-1:0] val; // Counter values
    modport src (output ev, output clr, input val);
    modport dst (input ev, input clr, output val);
endinterface : spcs_cnt_if

//--- hw/spcs_port_counters.sv
// Statistics counter bank of one port.
// Assumes events are one-cycle pulses on pclk.
`timescale 1ns/100ps
module spcs_port_counters
    import spcs_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Events in, values out
    spcs_cnt_if.dst cif
);
    genvar i;
    // One counter per event; wraps silently at the top
    generate
        for (i = 0; i < NCNT; i++) begin : g_cnt
            // A clear in the same cycle as an event leaves a count of one
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cif.val[i] <= '0;
                end else if (cif.clr) begin
                    cif.val[i] <= CW'(cif.ev[i]);
                end else begin
                    cif.val[i] <= cif.val[i] + CW'(cif.ev[i]);
                end
            end
        end
    endgenerate
endmodule : spcs_port_counters

//--- hw/spcs_port_resolve.sv
// Resolution of the running speed, duplex and flow control of one port.
// Assumes the PHY reports the partner's abilities once negotiation ends.
`timescale 1ns/100ps
module spcs_port_resolve
    import spcs_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Active config and port facts
    input wire spcs_cfg_type cfg,
    input wire logic gig,
    input wire logic link,
    // Partner abilities from negotiation
    input wire logic an_done,
    input wire logic [1:0] lp_speed,
    input wire logic lp_duplex,
    input wire logic lp_pause,
    // Resolved values
    output logic res_valid,
    output logic [1:0] res_speed,
    output logic res_duplex,
    output logic res_fc
);
    logic [1:0] own_max; // Fastest speed this port can run
    logic [1:0] an_spd; // Common speed after negotiation
    logic [1:0] fo_spd; // Forced speed, clamped to the port
    logic ok; // Result can be shown
    logic dup; // Chosen duplex
    assign own_max = gig ? SPD_1G : SPD_100;
    assign an_spd = (lp_speed < own_max) ? lp_speed : own_max;
    assign fo_spd = (cfg[CFG_SPD+:2] < own_max) ? cfg[CFG_SPD+:2] : own_max;
    assign ok = link && (!cfg[CFG_AN] || an_done);
    assign dup = cfg[CFG_AN] ? lp_duplex : cfg[CFG_DUP];

    // Register the outcome so status reads come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid <= 1'b0;
            res_speed <= SPD_NA;
            res_duplex <= 1'b0;
            res_fc <= 1'b0;
        end else if (!ok) begin
            res_valid <= 1'b0;
            res_speed <= SPD_NA;
            res_duplex <= 1'b0;
            res_fc <= 1'b0;
        end else begin
            res_valid <= 1'b1;
            res_speed <= cfg[CFG_AN] ? an_spd : fo_spd;
            res_duplex <= dup;
            // Pause needs full duplex, and the partner's consent if auto
            res_fc <= cfg[CFG_FC] && dup && (lp_pause || !cfg[CFG_AN]);
        end
    end
endmodule : spcs_port_resolve

//--- hw/spcs_switch_ports.sv
// Per-port control and statistics of a ten-port switch, on APB.
// Assumes frame events come from MAC logic on pclk; link pins are async.
`timescale 1ns/100ps
module spcs_switch_ports
    import spcs_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link pins from the PHYs (asynchronous)
    input wire logic [NPORT-1:0] link_pin,
    // Negotiation results from the PHYs
    input wire logic [NPORT-1:0] an_done,
    input wire logic [NPORT-1:0][1:0] lp_speed,
    input wire logic [NPORT-1:0] lp_duplex,
    input wire logic [NPORT-1:0] lp_pause,
    // Controls to the PHYs
    output logic [NPORT-1:0] phy_an_en,
    output logic [NPORT-1:0][1:0] phy_speed,
    output logic [NPORT-1:0] phy_duplex,
    // Receive frame reports from the MACs
    input wire logic [NPORT-1:0] rx_done,
    input wire logic [NPORT-1:0] rx_ok,
    input wire logic [NPORT-1:0] rx_bcast,
    input wire logic [NPORT-1:0] rx_mcast,
    input wire logic [NPORT-1:0] rx_src_known,
    input wire logic [NPORT-1:0] rx_full,
    // Transmit reports from the MACs
    input wire logic [NPORT-1:0] tx_done,
    input wire logic [NPORT-1:0] tx_ok,
    input wire logic [NPORT-1:0] tx_abort,
    input wire logic [NPORT-1:0] tx_col,
    // Gating and flow control to the MACs
    output logic [NPORT-1:0] tx_en,
    output logic [NPORT-1:0] rx_en,
    output logic [NPORT-1:0] rx_accept,
    output logic [NPORT-1:0] pause_send,
    output logic [15:0] pause_quanta
);
    // Bus decode
    logic [3:0] page; // 0 global, 1..10 ports
    logic [3:0] word; // Word within a page
    logic [3:0] pidx; // Port number of the page
    logic port_pg; // Address is on a port page
    logic glb_hit; // Global word
    logic prt_hit; // Mapped port word
    logic hit; // Any mapped word
    logic wr_acc; // Write in its access phase
    logic rd_setup; // Read in its setup phase
    logic [31:0] rd_mux; // Selected read value
    // Config and control
    spcs_cfg_type pend_reg [NPORT]; // Written, not yet applied
    spcs_cfg_type act_reg [NPORT]; // Settings in force
    logic apply_wr; // Apply request this cycle
    logic clr_reg; // Counter clear pulse
    logic clr_next;
    // Link synchroniser
    logic [NPORT-1:0] link_m_reg; // First stage, read by the second only
    logic [NPORT-1:0] link_reg; // Usable link level
    // Per-port status and readback
    logic [NPORT-1:0] res_valid;
    logic [NPORT-1:0][1:0] res_speed;
    logic [NPORT-1:0] res_duplex;
    logic [NPORT-1:0] res_fc;
    logic [NPORT-1:0] full_d_reg; // Last cycle's congestion level
    logic [31:0] port_rd [NPORT];
    logic [31:0] prdata_next;

    // Address fields
    assign page = paddr[9:6];
    assign word = paddr[5:2];
    assign pidx = 4'(page - 4'h1);
    assign port_pg = paddr[11:10] == 2'h0 && page != 4'h0 &&
                     page <= 4'(NPORT);
    assign glb_hit = paddr[11:10] == 2'h0 && page == 4'h0 &&
                     word == OFS_GLB;
    assign prt_hit = port_pg && (word <= OFS_STAT ||
                     (word >= OFS_CNT0 && word < 4'(OFS_CNT0 + NCNT)));
    assign hit = glb_hit || prt_hit;
    assign wr_acc = psel && penable && pwrite && hit;
    assign rd_setup = psel && !penable && !pwrite;
    assign rd_mux = prt_hit ? port_rd[pidx] : 32'h0000_0000;

    // Zero-wait slave; unmapped words answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign pause_quanta = PAUSE_QUANTA;

    assign apply_wr = wr_acc && glb_hit && pwdata[GLB_APPLY];
    assign clr_next = wr_acc && glb_hit && pwdata[GLB_CLEAR];
    // Global word reads as zero: its bits are actions, not state
    assign prdata_next = rd_setup ? rd_mux : prdata;

    // Read data is captured in the setup phase and held for access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= prdata_next;
        end
    end

    // Clear pulse, one cycle after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_reg <= 1'b0;
        end else begin
            clr_reg <= clr_next;
        end
    end

    // Two-stage synchroniser for the link pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_m_reg <= '0;
            link_reg <= '0;
        end else begin
            link_m_reg <= link_pin;
            link_reg <= link_m_reg;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            logic wr_cfg; // Write to this port's config word
            logic on; // Port enabled and linked
            logic pass; // Frame passes security and load checks
            logic seen; // Receive report while on
            logic tseen; // Transmit report while on
            logic [5:0] stat; // Status word bits
            spcs_cfg_type cfg_w; // Value written, read-only bits kept
            spcs_cnt_if cif ();

            assign wr_cfg = wr_acc && prt_hit && pidx == 4'(p) &&
                            word == OFS_CFG;
            assign cfg_w = pwdata[CFG_AN] ?
                {pwdata[CFG_SEC:CFG_FC], pend_reg[p][CFG_DUP:CFG_SPD],
                 pwdata[CFG_AN:CFG_EN]} : pwdata[6:0];

            // Pending and active settings of one port
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pend_reg[p] <= MEDIA_GIG[p] ? CFG_RST_GIG : CFG_RST_FE;
                    act_reg[p] <= MEDIA_GIG[p] ? CFG_RST_GIG : CFG_RST_FE;
                end else begin
                    if (wr_cfg) begin
                        pend_reg[p] <= cfg_w;
                    end
                    if (apply_wr) begin
                        act_reg[p] <= pend_reg[p];
                    end
                end
            end

            spcs_port_resolve u_res (
                .pclk(pclk),
                .presetn(presetn),
                .cfg(act_reg[p]),
                .gig(MEDIA_GIG[p]),
                .link(link_reg[p]),
                .an_done(an_done[p]),
                .lp_speed(lp_speed[p]),
                .lp_duplex(lp_duplex[p]),
                .lp_pause(lp_pause[p]),
                .res_valid(res_valid[p]),
                .res_speed(res_speed[p]),
                .res_duplex(res_duplex[p]),
                .res_fc(res_fc[p])
            );

            assign phy_an_en[p] = act_reg[p][CFG_AN];
            assign phy_speed[p] = act_reg[p][CFG_SPD+:2];
            assign phy_duplex[p] = act_reg[p][CFG_DUP];

            assign on = act_reg[p][CFG_EN] && link_reg[p];
            assign tx_en[p] = on;
            assign rx_en[p] = on;
            assign seen = rx_done[p] && on;
            assign tseen = tx_done[p] && on;
            assign pass = !(act_reg[p][CFG_SEC] && !rx_src_known[p]) &&
                          !(rx_full[p] && !res_fc[p]);
            assign rx_accept[p] = seen && rx_ok[p] && pass;

            assign cif.ev[CNT_TXG] = tseen && tx_ok[p];
            assign cif.ev[CNT_TXB] = tseen && !tx_ok[p];
            assign cif.ev[CNT_RXG] = rx_accept[p];
            assign cif.ev[CNT_RXB] = seen && !rx_ok[p];
            assign cif.ev[CNT_ABT] = tx_abort[p] && on;
            assign cif.ev[CNT_COL] = tx_col[p] && on;
            assign cif.ev[CNT_DRP] = seen && rx_ok[p] && !pass;
            assign cif.ev[CNT_BC] = rx_accept[p] && rx_bcast[p];
            assign cif.ev[CNT_MC] = rx_accept[p] && rx_mcast[p];
            assign cif.clr = clr_reg;

            spcs_port_counters u_cnt (
                .pclk(pclk),
                .presetn(presetn),
                .cif(cif.dst)
            );

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    full_d_reg[p] <= 1'b0;
                    pause_send[p] <= 1'b0;
                end else begin
                    full_d_reg[p] <= rx_full[p];
                    pause_send[p] <= rx_full[p] && !full_d_reg[p] &&
                                     res_fc[p] && on;
                end
            end

            assign stat = {res_fc[p], res_duplex[p], res_speed[p],
                           res_valid[p], MEDIA_GIG[p]};
            assign port_rd[p] =
                word == OFS_CFG ? {25'h0, pend_reg[p]} :
                word == OFS_ACT ? {25'h0, act_reg[p]} :
                word == OFS_STAT ? {25'h0, stat, link_reg[p]} :
                cif.val[4'(word - OFS_CNT0)];
        end
    endgenerate
endmodule : spcs_switch_ports

//--- verif/spcs_switch_ports_properties.sv
// Concurrent checks on the ports of the switch port block.
// Assumes one pclk domain and presetn asynchronous, active low.
`timescale 1ns/100ps
module spcs_switch_ports_properties
    import spcs_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Link and PHY control
    input wire logic [NPORT-1:0] link_pin,
    input wire logic [NPORT-1:0] phy_an_en,
    input wire logic [NPORT-1:0][1:0] phy_speed,
    input wire logic [NPORT-1:0] phy_duplex,
    // MAC side
    input wire logic [NPORT-1:0] rx_done,
    input wire logic [NPORT-1:0] rx_full,
    input wire logic [NPORT-1:0] tx_en,
    input wire logic [NPORT-1:0] rx_en,
    input wire logic [NPORT-1:0] rx_accept,
    input wire logic [NPORT-1:0] pause_send,
    input wire logic [15:0] pause_quanta
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0] apply_reg; // Apply strobe history
    logic apply_now; // Apply write taken this cycle
    assign apply_now = psel && penable && pwrite && paddr == 12'h000
        && pwdata[GLB_APPLY];
    // Delay the apply strobe so config moves can be traced back to it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apply_reg <= 2'h0;
        end else begin
            apply_reg <= {apply_reg[0], apply_now};
        end
    end
    chk_gate_pair: assert property (tx_en == rx_en)
        else $error("tx and rx enables differ");
    chk_accept_gated: assert property (
        (rx_accept & ~(rx_done & rx_en)) == '0)
        else $error("frame accepted on a closed port");
    chk_link_first: assert property (
        (tx_en & ~$past(link_pin, 2)) == '0)
        else $error("port opened before its link was seen");
    chk_pause_cause: assert property (
        (pause_send & ~($past(rx_full) & ~$past(rx_full, 2))) == '0)
        else $error("pause sent without a rise of the full flag");
    chk_pause_on: assert property (
        (pause_send & ~$past(rx_en)) == '0)
        else $error("pause sent by a closed port");
    chk_quanta_fixed: assert property (
        pause_quanta == PAUSE_QUANTA)
        else $error("pause time differs");
    chk_cfg_on_apply: assert property (
        !$stable({phy_an_en, phy_speed, phy_duplex}) |-> apply_reg[0])
        else $error("phy config moved without apply");
    chk_fe_speed_cap: assert property (
        phy_speed[0] != SPD_1G)
        else $error("fast port driven at gigabit");
    chk_read_hold: assert property (
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved outside a read");
endmodule : spcs_switch_ports_properties

//--- verif/spcs_link_partner.sv
// Remote link partners of all ports: link level and negotiation answers.
// Assumes the bench asks for link per port and picks pause ability.
`timescale 1ns/100ps
module spcs_link_partner
    import spcs_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Bench controls
    input wire logic [NPORT-1:0] link_req,
    input wire logic [NPORT-1:0] pause_ok,
    // Line side towards the block
    output logic [NPORT-1:0] link_pin,
    output logic [NPORT-1:0] an_done,
    output logic [NPORT-1:0][1:0] lp_speed,
    output logic [NPORT-1:0] lp_duplex,
    output logic [NPORT-1:0] lp_pause
);
    logic [NPORT-1:0][2:0] wait_reg; // Negotiation time per port
    initial begin
        {link_pin, an_done, lp_speed, lp_duplex, lp_pause} = '0;
        wait_reg = '0;
    end
    // answer abilities only once negotiation ends
    always @(posedge pclk) begin
        for (int p = 0; p < NPORT; p++) begin
            link_pin[p] <= link_req[p];
            if (!link_req[p]) begin
                wait_reg[p] <= 3'h0;
            end else if (wait_reg[p] != 3'h7) begin
                wait_reg[p] <= wait_reg[p] + 3'h1;
            end
            an_done[p] <= link_req[p] && wait_reg[p] == 3'h7;
            if (link_req[p] && wait_reg[p] == 3'h7) begin
                lp_speed[p] <= MEDIA_GIG[p] ? SPD_1G : SPD_100;
                lp_duplex[p] <= 1'b1;
                lp_pause[p] <= pause_ok[p];
            end else begin
                // Not settled: flicker so a stale value is never trusted
                lp_speed[p] <= ~lp_speed[p];
                lp_duplex[p] <= ~lp_duplex[p];
                lp_pause[p] <= ~lp_pause[p];
            end
        end
    end
endmodule : spcs_link_partner

//--- verif/spcs_switch_ports_bench.sv
// Self-checking bench of the switch port block.
// Assumes the APB slave answers with pready and counters sit per port.
`timescale 1ns/100ps
module spcs_switch_ports_bench
    import spcs_pkg::*;
;
    typedef struct packed {
        logic [9:0] ev; // Event bits towards the MAC report inputs
        logic [8:0] exp; // Expected counter values
        logic [8:0] care; // Counters that are compared
        logic [1:0] acc; // Accept compared, accept expected
    } spcs_row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, a, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [NPORT-1:0] link_pin, an_done, lp_duplex, lp_pause, link_req;
    logic [NPORT-1:0] phy_an_en, phy_duplex, tx_en, rx_en, pause_ok;
    logic [NPORT-1:0] rx_accept, pause_send;
    logic [NPORT-1:0][1:0] lp_speed, phy_speed;
    logic [15:0] pause_quanta;
    logic [9:0][NPORT-1:0] ev_bus; // All frame report inputs
    int errors = 0;
    int num_checks = 0;
    spcs_row_type rows [8];
    spcs_switch_ports i_spcs_switch_ports (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .link_pin, .an_done, .lp_speed, .lp_duplex, .lp_pause, .phy_an_en,
        .phy_speed, .phy_duplex, .rx_done(ev_bus[0]), .rx_ok(ev_bus[1]),
        .rx_bcast(ev_bus[2]), .rx_mcast(ev_bus[3]),
        .rx_src_known(ev_bus[5]), .rx_full(ev_bus[4]),
        .tx_done(ev_bus[6]), .tx_ok(ev_bus[7]), .tx_abort(ev_bus[8]),
        .tx_col(ev_bus[9]), .tx_en, .rx_en, .rx_accept, .pause_send,
        .pause_quanta);
    spcs_link_partner i_spcs_link_partner (.pclk, .link_req, .pause_ok,
        .link_pin, .an_done, .lp_speed, .lp_duplex, .lp_pause);
    // Clock at 50 MHz
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One APB transfer; the request holds until pready is seen
    task automatic apb(input logic wr, input logic [11:0] ad,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        n = 0;
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        // A slave that never answers is a mismatch, not a silent pass
        if (n == 50) errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] ad);
        apb(1'b0, ad, 32'h0, q, e);
    endtask : rd
    function automatic logic [11:0] pa(int p, int w);
        return 12'((p + 1) * 64 + w * 4);
    endfunction : pa
    // One-cycle frame report on port p; accept is sampled mid-cycle
    task automatic fire(input int p, input logic [9:0] ev);
        @(posedge pclk);
        for (int k = 0; k < 10; k++) ev_bus[k][p] <= ev[k];
        @(negedge pclk);
        a = rx_accept[p];
        @(posedge pclk);
        ev_bus <= '0;
    endtask : fire
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    // Watchdog far beyond the expected run of a few hundred cycles
    initial begin
        #400000;
        errors++;
        stop_test();
    end
    initial begin
        rows = '{'{10'h027, 9'h084, 9'h1FF, 2'h3},
            '{10'h02B, 9'h104, 9'h1FF, 2'h3},
            '{10'h021, 9'h008, 9'h1FF, 2'h0},
            '{10'h0C0, 9'h001, 9'h1FF, 2'h2},
            '{10'h040, 9'h002, 9'h1FF, 2'h2},
            '{10'h100, 9'h010, 9'h1FF, 2'h2},
            '{10'h200, 9'h020, 9'h1FF, 2'h2},
            '{10'h033, 9'h040, 9'h040, 2'h2}};
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ev_bus = '0;
        link_req = '0;
        pause_ok = 10'h040;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(pa(0, OFS_CFG));
        chk("cfg0", 32'h37, q);
        rd(pa(6, OFS_ACT));
        chk("act6", 32'h3B, q);
        rd(pa(9, OFS_STAT));
        chk("st9", 32'h1A, q & 32'h1F);
        apb(1'b0, 12'hFFC, 32'h0, q, e);
        chk("unmapped", 32'h1, {31'h0, e});
        link_req <= 10'h0C0;
        for (int n = 0; n < 30 && q[ST_VALID] !== 1'b1; n++) rd(pa(6, 2));
        chk("st6", 32'h77, q);
        rd(pa(7, OFS_STAT));
        chk("st7", 32'h2D, q);
        for (int r = 0; r < 8; r++) begin
            wr(12'h000, 32'h2);
            fire(7, rows[r].ev);
            if (rows[r].acc[1]) chk("accept", rows[r].acc[0], a);
            for (int i = 0; i < NCNT; i++) begin
                rd(pa(7, 4 + i));
                if (rows[r].care[i]) chk("count", rows[r].exp[i], q);
            end
        end
        @(posedge pclk);
        ev_bus[4][7:6] <= 2'b11;
        @(posedge pclk);
        @(negedge pclk);
        chk("pause", 32'h1, {30'h0, pause_send[7:6]});
        @(negedge pclk);
        chk("pause_end", 32'h0, {30'h0, pause_send[7:6]});
        @(posedge pclk);
        ev_bus <= '0;
        wr(pa(0, OFS_CFG), 32'h21);
        rd(pa(0, OFS_ACT));
        chk("act_old", 32'h37, q);
        wr(12'h000, 32'h1);
        rd(pa(0, OFS_ACT));
        chk("act_new", 32'h21, q);
        chk("forced", 32'h0, {phy_an_en[0], phy_duplex[0], phy_speed[0]});
        wr(pa(0, OFS_CFG), 32'h3F);
        rd(pa(0, OFS_CFG));
        chk("ro_bits", 32'h23, q);
        wr(pa(7, OFS_CFG), 32'h77);
        wr(12'h000, 32'h3);
        fire(7, 10'h003);
        chk("sec_block", 32'h0, a);
        rd(pa(7, 4 + CNT_DRP));
        chk("sec_drop", 32'h1, q);
        wr(pa(7, OFS_CFG), 32'h36);
        wr(12'h000, 32'h1);
        // The apply lands on the edge the task returns at; look mid-cycle
        @(negedge pclk);
        chk("tx_off", 32'h0, tx_en[7]);
        fire(7, 10'h027);
        chk("rx_off", 32'h0, a);
        link_req <= 10'h080;
        // Resolved status trails the link bit by one edge: wait for it
        for (int n = 0; n < 10 && (n == 0 || q[ST_VALID] !== 1'b0); n++)
            rd(pa(6, 2));
        chk("st6_down", 32'h1A, q & 32'h1F);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(pa(7, OFS_ACT));
        chk("act7_rst", 32'h37, q);
        stop_test();
    end
endmodule : spcs_switch_ports_bench
bind spcs_switch_ports spcs_switch_ports_properties i_props (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .link_pin, .phy_an_en, .phy_speed, .phy_duplex, .rx_done, .rx_full,
    .tx_en, .rx_en, .rx_accept, .pause_send, .pause_quanta);
